// ==== hw/comparator_pair_control_regs.sv ====
// Purpose: AHB-Lite register bank for a comparator pair with window function
// Assumes: Analog outputs, ready and window position arrive asynchronously;
//          event inputs are one-cycle pulses on hclk
// Notes:   Reads take one wait state, writes none
//
// Summary of operation
// [RULE1] Start bit one launches enabled single-shot comparison
// [RULE2] Start ignored unless implemented, enabled, single-shot
// [RULE3] Start bits always read back zero
// [RULE4] Event input enable lets events start comparisons
// [RULE5] Any routed event acts, source not recorded
// [RULE6] Window event output only when enabled
// [RULE7] Comparator event output only when enabled
// [RULE8] Reserved bits read zero; software writes zero
// [RULE9] Enable-clear reads enables, one bits disable
// [RULE10] Enable-set reads enables, one bits enable
// [RULE11] Set and clear share one enable store
// [RULE12] Window flag set on selected window condition
// [RULE13] Comparator flag set on selected condition
// [RULE14] Writing one clears a flag
// [RULE15] Unimplemented comparator flag reads zero
// [RULE16] Window position codes above, inside, below
// [RULE17] Window position live only in window mode
// [RULE18] State bits mirror outputs, valid when ready
// [RULE19] Window condition codes above/inside/below/outside
// [RULE20] Interrupt raised when flag and enable set
//
// The AHB-Lite slave port was left to the implementer.
`include "cmp_pair_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module comparator_pair_control_regs #(
    parameter logic [1:0] CMP_PRESENT    = 2'b11,
    parameter logic       WINDOW_PRESENT = 1'b1,
    parameter int         EV_CHANNELS    = 2
) (
    // Clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // AHB-Lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic                          hresp,
    output logic [31:0]                   hrdata,
    // Analog comparator side
    input  wire cmp_pair_pkg::pair_t      cmp_out_in,
    input  wire cmp_pair_pkg::pair_t      cmp_ready_in,
    input  wire logic [1:0]               window_pos_in,
    output cmp_pair_pkg::pair_t           cmp_enable,
    output cmp_pair_pkg::pair_t           cmp_launch,
    // Event routing network
    input  wire logic [EV_CHANNELS-1:0]   event_in,
    output cmp_pair_pkg::pair_t           cmp_event_out,
    output logic                          window_event_out,
    // Interrupt request
    output logic                          irq
);
    import cmp_pair_pkg::*;

    localparam logic [7:0] IMPL_MASK = {3'h0, WINDOW_PRESENT, 2'h0, CMP_PRESENT};

    bus_state_e  bus_state_reg;
    reg_index_t  rd_idx_reg;
    reg_index_t  wr_idx_reg;
    logic        wr_pend_reg;
    logic [31:0] hrdata_reg;
    logic [15:0] event_routing_control_reg;
    logic [7:0]  irq_en_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  flag_set;
    logic [7:0]  cmp_cfg_reg [2];
    logic [7:0]  win_cfg_reg;
    logic [5:0]  sync1_reg;
    logic [5:0]  sync2_reg;
    logic [5:0]  sync3_reg;
    logic [5:0]  stable_reg;
    logic [5:0]  prev_reg;
    logic        win_hit_prev_reg;
    pair_t       launch_reg;
    pair_t       cmp_ev_reg;
    logic        win_ev_reg;
    logic        bus_take;
    logic [5:0]  agree;
    pair_t       cmp_lvl;
    pair_t       cmp_rdy;
    pair_t       cfg_en;
    pair_t       cfg_single;
    pair_t       sw_start;
    pair_t       launch_next;
    pair_t       cmp_change;
    logic        win_on;
    logic [1:0]  wpos;
    logic        win_hit;

    function automatic logic wr_hit(input reg_index_t idx);
        return wr_pend_reg && (wr_idx_reg == idx);
    endfunction

    function automatic logic cmp_cond_hit(input logic [1:0] cond, input logic rise,
                                          input logic fall, input logic done);
        case (cmp_cond_e'(cond))
            CCOND_TOGGLE: return rise | fall;
            CCOND_RISE:   return rise;
            CCOND_FALL:   return fall;
            CCOND_DONE:   return done;
            default:      return 1'b0;
        endcase
    endfunction

    // [RULE19] window condition decode
    function automatic logic win_cond_hit(input logic [1:0] cond, input logic [1:0] pos);
        case (window_cond_e'(cond))
            WCOND_ABOVE:   return pos == POS_ABOVE;
            WCOND_INSIDE:  return pos == POS_INSIDE;
            WCOND_BELOW:   return pos == POS_BELOW;
            WCOND_OUTSIDE: return (pos == POS_ABOVE) || (pos == POS_BELOW);
            default:       return 1'b0;
        endcase
    endfunction

    // ---------------- Bus slave ----------------
    assign bus_take  = hsel && hready && htrans[1];
    assign hreadyout = (bus_state_reg == BUS_IDLE);
    assign hresp     = `HRESP_OKAY;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= BUS_IDLE;
            rd_idx_reg    <= 6'h00;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (bus_take && !hwrite) begin
                        bus_state_reg <= BUS_READ;
                        rd_idx_reg    <= haddr[7:2];
                    end
                end
                BUS_READ: begin
                    bus_state_reg <= BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    // Only whole-word writes are applied; others complete OKAY and are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 6'h00;
        end else begin
            wr_pend_reg <= bus_take && hwrite && (hsize == `HSIZE_WORD);
            wr_idx_reg  <= haddr[7:2];
        end
    end

    // Read data is sampled one cycle after the address phase, so a write in the
    // preceding data phase is already visible.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (bus_state_reg == BUS_READ) begin
            // [RULE8] [RULE3] unlisted bits zero
            case (rd_idx_reg)
                `IDX_EVENT_ROUTING_CONTROL:      hrdata_reg <= {16'h0000, event_routing_control_reg};
                `IDX_IRQ_EN_CLR,
                `IDX_IRQ_EN_SET:  hrdata_reg <= {24'h000000, irq_en_reg};
                `IDX_IRQ_FLAGS:   hrdata_reg <= {24'h000000, flags_reg};
                // [RULE17] [RULE18] live status
                `IDX_LIVE_STATUS: hrdata_reg <= {26'h0, wpos, 2'h0, cmp_lvl & CMP_PRESENT};
                `IDX_READINESS:   hrdata_reg <= {30'h0, cmp_rdy & CMP_PRESENT};
                `IDX_WIN_CFG:     hrdata_reg <= {24'h000000, win_cfg_reg};
                `IDX_CMP_CFG0:    hrdata_reg <= {24'h000000, cmp_cfg_reg[0]};
                `IDX_CMP_CFG1:    hrdata_reg <= {24'h000000, cmp_cfg_reg[1]};
                default:          hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------- Configuration ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_routing_control_reg     <= `EVENT_ROUTING_CONTROL_RST;
            win_cfg_reg    <= `WIN_CFG_RST;
            cmp_cfg_reg[0] <= `CMP_CFG_RST;
            cmp_cfg_reg[1] <= `CMP_CFG_RST;
        end else begin
            if (wr_hit(`IDX_EVENT_ROUTING_CONTROL)) begin
                event_routing_control_reg <= hwdata[15:0] & `EVENT_ROUTING_CONTROL_MASK;
            end
            if (wr_hit(`IDX_WIN_CFG)) begin
                win_cfg_reg <= hwdata[7:0] & `WIN_CFG_MASK & {7'h7f, WINDOW_PRESENT};
            end
            if (wr_hit(`IDX_CMP_CFG0)) begin
                cmp_cfg_reg[0] <= hwdata[7:0] & `CMP_CFG_MASK & {7'h7f, CMP_PRESENT[0]};
            end
            if (wr_hit(`IDX_CMP_CFG1)) begin
                cmp_cfg_reg[1] <= hwdata[7:0] & `CMP_CFG_MASK & {7'h7f, CMP_PRESENT[1]};
            end
        end
    end

    assign cfg_en     = {cmp_cfg_reg[1][`CFG_EN_BIT], cmp_cfg_reg[0][`CFG_EN_BIT]};
    assign cfg_single = {cmp_cfg_reg[1][`CFG_SINGLE_BIT], cmp_cfg_reg[0][`CFG_SINGLE_BIT]};
    assign cmp_enable = cfg_en;
    assign win_on     = win_cfg_reg[`WIN_EN_BIT] && WINDOW_PRESENT;

    // [RULE9] [RULE10] [RULE11] one enable store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_reg <= `IRQ_EN_RST;
        end else if (wr_hit(`IDX_IRQ_EN_SET)) begin
            irq_en_reg <= irq_en_reg | (hwdata[7:0] & `IRQ_MASK & IMPL_MASK);
        end else if (wr_hit(`IDX_IRQ_EN_CLR)) begin
            irq_en_reg <= irq_en_reg & ~hwdata[7:0];
        end
    end

    // ---------------- Analog inputs ----------------
    // Three stages; a bit moves on only when stages two and three agree
    assign agree = ~(sync2_reg ^ sync3_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg  <= 6'h00;
            sync2_reg  <= 6'h00;
            sync3_reg  <= 6'h00;
            stable_reg <= 6'h00;
            prev_reg   <= 6'h00;
        end else begin
            sync1_reg  <= {window_pos_in, cmp_ready_in, cmp_out_in};
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            stable_reg <= (agree & sync3_reg) | (~agree & stable_reg);
            prev_reg   <= stable_reg;
        end
    end

    assign cmp_lvl = stable_reg[1:0];
    assign cmp_rdy = stable_reg[3:2];
    // [RULE16] [RULE17] position code, zero outside window mode
    assign wpos    = win_on ? stable_reg[5:4] : 2'h0;
    assign win_hit = win_on && win_cond_hit(win_cfg_reg[`WIN_COND_LSB +: 2], wpos);
    assign cmp_change = (cmp_lvl ^ prev_reg[1:0]) & cmp_rdy & cfg_en & CMP_PRESENT;

    // ---------------- Launch and events ----------------
    // [RULE3] start bits are a strobe only, never stored
    assign sw_start = wr_hit(`IDX_TRIGGER) ? hwdata[1:0] : 2'h0;

    always_comb begin
        // [RULE1] [RULE2] gated single-shot start
        launch_next = sw_start & cfg_single & cfg_en & CMP_PRESENT;
        // [RULE4] [RULE5] any routed event
        if (|event_in) begin
            launch_next = launch_next
                        | (event_routing_control_reg[`EV_IN_LSB +: 2] & cfg_en & CMP_PRESENT);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            launch_reg       <= 2'h0;
            cmp_ev_reg       <= 2'h0;
            win_ev_reg       <= 1'b0;
            win_hit_prev_reg <= 1'b0;
        end else begin
            launch_reg       <= launch_next;
            // [RULE7] comparator event gate
            cmp_ev_reg       <= cmp_change & event_routing_control_reg[1:0];
            // [RULE6] window event gate
            win_ev_reg       <= win_on && (stable_reg[5:4] != prev_reg[5:4])
                                && event_routing_control_reg[`EV_WIN_OUT_BIT];
            win_hit_prev_reg <= win_hit;
        end
    end

    assign cmp_launch       = launch_reg;
    assign cmp_event_out    = cmp_ev_reg;
    assign window_event_out = win_ev_reg;

    // ---------------- Interrupt flags ----------------
    always_comb begin
        flag_set = 8'h00;
        for (int i = 0; i < 2; i++) begin
            // [RULE13] comparator condition
            flag_set[i] = CMP_PRESENT[i] && cfg_en[i]
                && cmp_cond_hit(cmp_cfg_reg[i][`CFG_COND_LSB +: 2],
                                cmp_change[i] && cmp_lvl[i],
                                cmp_change[i] && !cmp_lvl[i],
                                cmp_rdy[i] && !prev_reg[2 + i]);
        end
        // [RULE12] window condition entered
        flag_set[`IRQ_WIN_BIT] = win_hit && !win_hit_prev_reg;
        // [RULE14] [RULE15] set wins over clear
        flags_next = flags_reg;
        if (wr_hit(`IDX_IRQ_FLAGS)) begin
            flags_next = flags_reg & ~hwdata[7:0];
        end
        flags_next = (flags_next | flag_set) & `IRQ_MASK & IMPL_MASK;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= `IRQ_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // [RULE20] flag and enable
    assign irq = |(flags_reg & irq_en_reg);

    // ---------------- Checks ----------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    launch_sw_a: assert property (wr_hit(`IDX_TRIGGER) && hwdata[0] && cfg_en[0] // [RULE1]
        && cfg_single[0] && CMP_PRESENT[0] |=> cmp_launch[0])
        else $error("single-shot start did not launch comparator 0");
    launch_gate_a: assert property (cmp_launch[1] |-> $past(cfg_en[1])) // [RULE2]
        else $error("launch on a disabled comparator");
    start_read_a: assert property (bus_state_reg == BUS_READ // [RULE3]
        && rd_idx_reg == `IDX_TRIGGER |=> hrdata == 32'h0)
        else $error("start bits read nonzero");
    evin_off_a: assert property (|event_in && !event_routing_control_reg[`EV_IN_LSB] // [RULE4]
        && !wr_hit(`IDX_TRIGGER) |=> !cmp_launch[0])
        else $error("event launched with input enable off");
    win_evout_a: assert property (window_event_out |-> $past(event_routing_control_reg[`EV_WIN_OUT_BIT])) // [RULE6]
        else $error("window event while disabled");
    cmp_evout_a: assert property (cmp_event_out[0] |-> $past(event_routing_control_reg[0])) // [RULE7]
        else $error("comparator event while disabled");
    en_set_a: assert property (wr_hit(`IDX_IRQ_EN_SET) && hwdata[4] && WINDOW_PRESENT // [RULE10]
        |=> irq_en_reg[4])
        else $error("enable set not taken");
    en_share_a: assert property (bus_state_reg == BUS_READ // [RULE11]
        && rd_idx_reg == `IDX_IRQ_EN_CLR |=> hrdata[7:0] == $past(irq_en_reg))
        else $error("enable clear read differs from enable store");
    en_clr_a: assert property (wr_hit(`IDX_IRQ_EN_CLR) && hwdata[0] |=> !irq_en_reg[0]) // [RULE9]
        else $error("enable clear not taken");
    flag_clear_a: assert property (wr_hit(`IDX_IRQ_FLAGS) && hwdata[1] // [RULE14]
        && !flag_set[1] |=> !flags_reg[1])
        else $error("flag not cleared by write of one");
    flag_keep_a: assert property (flag_set[0] |=> flags_reg[0] || !CMP_PRESENT[0]) // [RULE13]
        else $error("comparator flag lost");
    win_pos_a: assert property (!win_on && bus_state_reg == BUS_READ // [RULE17]
        && rd_idx_reg == `IDX_LIVE_STATUS |=> hrdata[5:4] == 2'h0)
        else $error("window position shown outside window mode");
    irq_rise_a: assert property ($rose(flags_reg[4]) && irq_en_reg[4] |-> irq) // [RULE20]
        else $error("interrupt not raised");
    read_wait_a: assert property (bus_take && !hwrite && hreadyout // [RULE8]
        |=> !hreadyout ##1 (hreadyout && hrdata[31:16] == 16'h0))
        else $error("read timing or reserved bits wrong");

    sw_launch_c: cover property (wr_hit(`IDX_TRIGGER) ##1 cmp_launch[0]);
    ev_launch_c: cover property (|event_in ##1 cmp_launch[1]);
    win_flag_c:  cover property (flag_set[`IRQ_WIN_BIT] ##1 irq);
    status_rd_c: cover property (bus_state_reg == BUS_READ && rd_idx_reg == `IDX_LIVE_STATUS);

endmodule

`default_nettype wire

// ==== hw/cmp_pair_regs.svh ====
// Purpose: Register indices, field positions, masks and reset values
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef CMP_PAIR_REGS_SVH
`define CMP_PAIR_REGS_SVH

// Register indices (byte address = index * 4)
`define IDX_TRIGGER      6'h01
`define IDX_EVENT_ROUTING_CONTROL       6'h02
`define IDX_IRQ_EN_CLR   6'h04
`define IDX_IRQ_EN_SET   6'h05
`define IDX_IRQ_FLAGS    6'h06
`define IDX_LIVE_STATUS  6'h08
`define IDX_READINESS    6'h09
`define IDX_WIN_CFG      6'h0c
`define IDX_CMP_CFG0     6'h10
`define IDX_CMP_CFG1     6'h14

// Field positions
`define EV_IN_LSB        8
`define EV_WIN_OUT_BIT   4
`define IRQ_WIN_BIT      4
`define WPOS_LSB         4
`define CFG_EN_BIT       0
`define CFG_SINGLE_BIT   1
`define CFG_COND_LSB     5
`define WIN_EN_BIT       0
`define WIN_COND_LSB     1

// Writable bits and reset values
`define EVENT_ROUTING_CONTROL_MASK      16'h0313
`define IRQ_MASK         8'h13
`define CMP_CFG_MASK     8'h63
`define WIN_CFG_MASK     8'h07
`define EVENT_ROUTING_CONTROL_RST       16'h0000
`define IRQ_EN_RST       8'h00
`define IRQ_FLAGS_RST    8'h00
`define CMP_CFG_RST      8'h00
`define WIN_CFG_RST      8'h00

// Bus encodings
`define HSIZE_WORD       3'h2
`define HRESP_OKAY       1'h0

`endif

// ==== hw/cmp_pair_pkg.sv ====
// Purpose: Types shared by the comparator pair register block
// Assumes: Nothing
// Notes:   Enum order gives the field encodings
package cmp_pair_pkg;
    typedef logic [1:0] pair_t;
    typedef logic [5:0] reg_index_t;
    typedef enum logic [1:0] {POS_ABOVE, POS_INSIDE, POS_BELOW, POS_RESERVED} window_pos_e;
    typedef enum logic [1:0] {WCOND_ABOVE, WCOND_INSIDE, WCOND_BELOW, WCOND_OUTSIDE} window_cond_e;
    typedef enum logic [1:0] {CCOND_TOGGLE, CCOND_RISE, CCOND_FALL, CCOND_DONE} cmp_cond_e;
    typedef enum logic {BUS_IDLE, BUS_READ} bus_state_e;
endpackage

// ==== bench/cmp_far_side_model.sv ====
// Purpose: Far side of the block: comparator pair, window detector, event channels
// Assumes: A comparator settles READY_LAT cycles after enable or launch
// Notes:   Levels come from the bench; an unsettled output shows the inverse level
`timescale 1ns/10ps
`default_nettype none

module cmp_far_side_model #(
    parameter int READY_LAT = 4
) (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Bench controls
    input  wire logic [1:0] lvl,
    input  wire logic [1:0] pos,
    input  wire logic [1:0] ev_req,
    // Block side
    input  wire logic [1:0] cmp_enable,
    input  wire logic [1:0] cmp_launch,
    output logic [1:0]      cmp_out_in,
    output logic [1:0]      cmp_ready_in,
    output logic [1:0]      window_pos_in,
    output logic [1:0]      event_in
);
    int settle [2];

    // Not ready while off or busy with a launched comparison
    always @(posedge hclk or negedge hresetn) begin
        for (int i = 0; i < 2; i++) begin
            if (!hresetn || !cmp_enable[i] || cmp_launch[i]) begin
                settle[i] <= READY_LAT;
            end else if (settle[i] > 0) begin
                settle[i] <= settle[i] - 1;
            end
        end
    end

    always @(posedge hclk) begin
        event_in <= ev_req;
    end

    assign cmp_ready_in  = {settle[1] == 0, settle[0] == 0};
    assign cmp_out_in    = (lvl & cmp_ready_in) | (~lvl & ~cmp_ready_in);
    assign window_pos_in = pos;
endmodule
`default_nettype wire

// ==== bench/comparator_pair_control_regs_tb.sv ====
// Purpose: Self-checking bench for the comparator pair register block
// Assumes: One AHB-Lite slave, hready fed back from hreadyout
// Notes:   Table rows check register access; hand tests follow
`include "cmp_pair_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module comparator_pair_control_regs_tb;
    import cmp_pair_pkg::*;
    typedef struct {logic [5:0] idx; logic [31:0] wd; logic [31:0] exp;} row_s;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, window_event_out, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, window_pos_in, event_in, lvl, pos, ev_req;
    logic [2:0]  hsize;
    pair_t       cmp_out_in, cmp_ready_in, cmp_enable, cmp_launch, cmp_event_out;
    int          n_fail, tests_run, n_launch [2], n_cev [2], n_wev;
    logic [1:0]  s_tab [4] = '{2'h1, 2'h0, 2'h1, 2'h1};
    logic [1:0]  t_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    row_s rows [10] = '{
        '{`IDX_EVENT_ROUTING_CONTROL, 32'hffffffff, 32'h313}, '{`IDX_IRQ_EN_SET, 32'hffffffff, 32'h13},
        '{`IDX_IRQ_EN_CLR, 32'h0, 32'h13}, '{`IDX_IRQ_EN_CLR, 32'h1, 32'h12},
        '{`IDX_IRQ_EN_SET, 32'h0, 32'h12}, '{`IDX_IRQ_EN_CLR, 32'hff, 32'h0},
        '{`IDX_TRIGGER, 32'h3, 32'h0}, '{6'h07, 32'hffffffff, 32'h0},
        '{`IDX_IRQ_FLAGS, 32'hff, 32'h0}, '{`IDX_EVENT_ROUTING_CONTROL, 32'h0, 32'h0}};

    comparator_pair_control_regs comparator_pair_control_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_out_in(cmp_out_in),
        .cmp_ready_in(cmp_ready_in), .window_pos_in(window_pos_in), .cmp_enable(cmp_enable),
        .cmp_launch(cmp_launch), .event_in(event_in), .cmp_event_out(cmp_event_out),
        .window_event_out(window_event_out), .irq(irq));

    cmp_far_side_model cmp_far_side_model_i (
        .hclk(hclk), .hresetn(hresetn), .lvl(lvl), .pos(pos), .ev_req(ev_req),
        .cmp_enable(cmp_enable), .cmp_launch(cmp_launch), .cmp_out_in(cmp_out_in),
        .cmp_ready_in(cmp_ready_in), .window_pos_in(window_pos_in), .event_in(event_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Pulse counters for launches and event outputs
    always @(posedge hclk) begin
        for (int i = 0; i < 2; i++) begin
            n_launch[i] += int'(cmp_launch[i]);
            n_cev[i] += int'(cmp_event_out[i]);
        end
        n_wev += int'(window_event_out);
    end

    task automatic results();
        $display("Checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= `HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(what, rd, exp);
    endtask

    initial begin
        repeat (10000) @(posedge hclk);
        n_fail++;
        results();
    end

    initial begin
        int b0;
        int b1;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata, lvl, pos, ev_req} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("hreadyout", 32'(hreadyout), 32'h1);
        chk("hresp", 32'(hresp), 32'(`HRESP_OKAY));
        rchk("event_routing_control rst", `IDX_EVENT_ROUTING_CONTROL, 32'(`EVENT_ROUTING_CONTROL_RST));
        rchk("en rst", `IDX_IRQ_EN_SET, 32'(`IRQ_EN_RST));
        rchk("flags rst", `IDX_IRQ_FLAGS, 32'(`IRQ_FLAGS_RST));
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].idx, rows[i].wd);
            rchk("row", rows[i].idx, rows[i].exp);
        end
        // Software launch: comparator 0 single-shot, comparator 1 continuous
        xfer(1'b1, `IDX_CMP_CFG0, 32'h03);
        xfer(1'b1, `IDX_CMP_CFG1, 32'h01);
        repeat (8) @(posedge hclk);
        chk("enable", 32'(cmp_enable), 32'h3);
        xfer(1'b1, `IDX_TRIGGER, 32'h3);
        #1 chk("launch", 32'(cmp_launch), 32'h1);
        @(posedge hclk);
        #1 chk("launch end", 32'(cmp_launch), 32'h0);
        xfer(1'b1, `IDX_TRIGGER, 32'h0);
        #1 chk("launch zero", 32'(cmp_launch), 32'h0);
        // Event input launches
        xfer(1'b1, `IDX_EVENT_ROUTING_CONTROL, 32'h300);
        b0 = n_launch[0];
        b1 = n_launch[1];
        ev_req <= 2'b10;
        @(posedge hclk);
        ev_req <= 2'b00;
        repeat (6) @(posedge hclk);
        chk("ev launch", {16'(n_launch[1] - b1), 16'(n_launch[0] - b0)}, 32'h0001_0001);
        xfer(1'b1, `IDX_EVENT_ROUTING_CONTROL, 32'h0);
        ev_req <= 2'b01;
        @(posedge hclk);
        ev_req <= 2'b00;
        repeat (6) @(posedge hclk);
        chk("ev off", 32'(n_launch[0] - b0), 32'h1);
        // Comparator toggle: flag, event output, status, irq
        xfer(1'b1, `IDX_EVENT_ROUTING_CONTROL, 32'h1);
        repeat (8) @(posedge hclk);
        xfer(1'b1, `IDX_IRQ_FLAGS, 32'h13);
        b0 = n_cev[0];
        lvl <= 2'b01;
        repeat (8) @(posedge hclk);
        rchk("cmp flag", `IDX_IRQ_FLAGS, 32'h1);
        chk("cmp event", 32'(n_cev[0] - b0), 32'h1);
        rchk("state", `IDX_LIVE_STATUS, 32'h1);
        chk("irq off", 32'(irq), 32'h0);
        xfer(1'b1, `IDX_IRQ_EN_SET, 32'h1);
        #1 chk("irq on", 32'(irq), 32'h1);
        xfer(1'b1, `IDX_IRQ_FLAGS, 32'h10);
        rchk("flag kept", `IDX_IRQ_FLAGS, 32'h1);
        xfer(1'b1, `IDX_IRQ_FLAGS, 32'h1);
        rchk("flag clr", `IDX_IRQ_FLAGS, 32'h0);
        chk("irq clr", 32'(irq), 32'h0);
        xfer(1'b1, `IDX_EVENT_ROUTING_CONTROL, 32'h0);
        lvl <= 2'b00;
        repeat (8) @(posedge hclk);
        chk("cmp ev off", 32'(n_cev[0] - b0), 32'h1);
        xfer(1'b1, `IDX_IRQ_EN_CLR, 32'h13);
        // Window conditions, position codes and window events
        xfer(1'b1, `IDX_EVENT_ROUTING_CONTROL, 32'h10);
        for (int c = 0; c < 4; c++) begin
            pos <= s_tab[c];
            xfer(1'b1, `IDX_WIN_CFG, 32'(1 + 2 * c));
            repeat (8) @(posedge hclk);
            xfer(1'b1, `IDX_IRQ_FLAGS, 32'h13);
            b0 = n_wev;
            pos <= t_tab[c];
            repeat (8) @(posedge hclk);
            rchk("win flag", `IDX_IRQ_FLAGS, 32'h10);
            rchk("win pos", `IDX_LIVE_STATUS, 32'(t_tab[c]) << 4);
            chk("win event", 32'(n_wev - b0), 32'h1);
        end
        xfer(1'b1, `IDX_EVENT_ROUTING_CONTROL, 32'h0);
        b0 = n_wev;
        pos <= 2'h0;
        repeat (8) @(posedge hclk);
        chk("win ev off", 32'(n_wev - b0), 32'h0);
        xfer(1'b1, `IDX_WIN_CFG, 32'h0);
        repeat (8) @(posedge hclk);
        rchk("win off pos", `IDX_LIVE_STATUS, 32'h0);
        // Reset in mid-run clears configuration and the shared enables
        xfer(1'b1, `IDX_IRQ_EN_SET, 32'h13);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("enable mid rst", 32'(cmp_enable), 32'h0);
        chk("irq mid rst", 32'(irq), 32'h0);
        rchk("en mid rst", `IDX_IRQ_EN_CLR, 32'(`IRQ_EN_RST));
        results();
    end
endmodule
`default_nettype wire
